// ==== core/crs_core_regs.sv ====
// Behaviour
// (RULE1) Eight-bit accumulator for ALU operands and results
// (RULE2) Two index registers; prefix redirects to second
// (RULE3) Interrupt context never saves the second index
// (RULE4) Sixteen-bit pointer from separately handled bytes
// (RULE5) Flags: top ones, H I N Z C
// (RULE6) Flags pushable, poppable and individually controlled
// (RULE7) Half carry from bit three on adds
// (RULE8) Mask set on entry, software sets/clears
// (RULE9) Masked requests latched and kept pending
// (RULE10) Unmask serves pending at once; return restores
// (RULE11) Negative copies result bit seven
// (RULE12) Zero set when result is zero
// (RULE13) Carry from arithmetic, set/clear, shifts, bit tests
// (RULE14) Branches test five flags either sense
// (RULE15) Pointer: decrement after push, increment before pop
// (RULE16) Sixty-four byte stack, reset to top
// (RULE17) Load instruction reads and writes pointer low
// (RULE18) Pointer wraps silently both directions
// (RULE19) Entry stores low pointer first, five bytes
// (RULE20) Entry order low, high, X, A, flags
`timescale 1ns/1ps
module crs_core_regs (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	// Prefix from the decoder
	input  wire logic                 pre_y,
	// Direct register write
	input  wire logic                 reg_we,
	input  crs_pkg::crs_reg_type      reg_sel,
	input  wire logic [7:0]           reg_wdata,
	// ALU result write-back
	input  wire logic                 alu_we,
	input  crs_pkg::crs_reg_type      alu_dest,
	input  wire logic [7:0]           alu_result,
	input  wire logic                 alu_half_en,
	input  wire logic                 alu_half,
	input  wire logic                 alu_carry_en,
	input  wire logic                 alu_carry,
	// Flag and stack reset instructions
	input  wire logic                 carry_set_instr,
	input  wire logic                 carry_clear_instr,
	input  wire logic                 mask_instr,
	input  wire logic                 unmask_instr,
	input  wire logic                 stack_reset_instr,
	// Instruction pointer control
	input  wire logic                 ip_inc,
	input  wire logic                 ip_low_we,
	input  wire logic                 ip_high_we,
	input  wire logic [7:0]           ip_wdata,
	// Stack sequence command
	input  wire logic                 cmd_start,
	input  crs_pkg::crs_cmd_type      cmd,
	input  crs_pkg::crs_reg_type      cmd_reg,
	input  wire logic                 cmd_trap,
	// Branch condition test
	input  wire logic                 cond_req,
	input  crs_pkg::crs_cond_type     cond_sel,
	input  wire logic                 cond_when_set,
	// Interrupt requests
	input  wire logic                 irq_req,
	// Stack memory
	input  wire logic [7:0]           stk_rdata,
	output logic                      stk_wr_r,
	output logic                      stk_rd_r,
	output logic      [15:0]          stk_addr_r,
	output logic      [7:0]           stk_wdata_r,
	// Register contents
	output logic      [7:0]           acc_r,
	output logic      [7:0]           idx_x_r,
	output logic      [7:0]           idx_y_r,
	output logic      [7:0]           instr_ptr_low,
	output logic      [7:0]           instr_ptr_high,
	output logic      [7:0]           flag_register,
	output logic      [15:0]          stack_pointer,
	// Status
	output logic                      busy_r,
	output logic                      seq_done_r,
	output logic                      int_pending_r,
	output logic                      int_ready_r,
	output logic                      branch_valid_r,
	output logic                      branch_take_r
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH,
		ST_POP_ISSUE,
		ST_POP_HOLD,
		ST_POP_CAP
	} crs_state_type;

	crs_state_type        state_r;
	crs_pkg::crs_cmd_type kind_r;
	crs_pkg::crs_reg_type one_reg_r;
	logic [2:0]           idx_r;
	logic [2:0]           len_r;

	// Redirect an index X selection to Y under the prefix
	function automatic crs_pkg::crs_reg_type redirect(input crs_pkg::crs_reg_type sel, input logic py);
		if (sel == crs_pkg::REG_IDX_X && py)
			return crs_pkg::REG_IDX_Y;
		return sel;
	endfunction

	// Number of stack bytes a sequence moves
	function automatic logic [2:0] seq_len(input crs_pkg::crs_cmd_type k);
		case (k)
			crs_pkg::CMD_INT_ENTRY,
			crs_pkg::CMD_INTERRUPT_RETURN_INSTR: return crs_pkg::LEN_INT;
			crs_pkg::CMD_CALL,
			crs_pkg::CMD_RET: return crs_pkg::LEN_CALL;
			default: return crs_pkg::LEN_ONE;
		endcase
	endfunction

	// Register moved at step i; pops walk the push order backwards
	function automatic crs_pkg::crs_reg_type seq_reg(input crs_pkg::crs_cmd_type k, input logic [2:0] i,
			input crs_pkg::crs_reg_type one);
		case (k)
			crs_pkg::CMD_INT_ENTRY: begin
				case (i)
					3'h0: return crs_pkg::REG_PCL;
					3'h1: return crs_pkg::REG_PCH;
					3'h2: return crs_pkg::REG_IDX_X;
					3'h3: return crs_pkg::REG_ACC;
					default: return crs_pkg::REG_FLAGS;
				endcase
			end
			crs_pkg::CMD_INTERRUPT_RETURN_INSTR: begin
				case (i)
					3'h0: return crs_pkg::REG_FLAGS;
					3'h1: return crs_pkg::REG_ACC;
					3'h2: return crs_pkg::REG_IDX_X;
					3'h3: return crs_pkg::REG_PCH;
					default: return crs_pkg::REG_PCL;
				endcase
			end
			crs_pkg::CMD_CALL: return (i == 3'h0) ? crs_pkg::REG_PCL : crs_pkg::REG_PCH;
			crs_pkg::CMD_RET: return (i == 3'h0) ? crs_pkg::REG_PCH : crs_pkg::REG_PCL;
			default: return one;
		endcase
	endfunction

	// Register, ALU, flag and stack strobes are only honoured while no sequence runs
	logic idle;
	logic go;
	logic is_push_cmd;
	assign idle        = (state_r == ST_IDLE);
	assign go          = idle && cmd_start && (cmd != crs_pkg::CMD_NONE);
	assign is_push_cmd = (cmd == crs_pkg::CMD_PUSH) || (cmd == crs_pkg::CMD_CALL) || (cmd == crs_pkg::CMD_INT_ENTRY);

	crs_pkg::crs_reg_type wsel;
	crs_pkg::crs_reg_type asel;
	crs_pkg::crs_reg_type cur_reg;
	logic                 wr_ok;
	logic                 alu_ok;
	logic                 cap;
	assign wsel    = redirect(reg_sel, pre_y); // RULE2
	assign asel    = redirect(alu_dest, pre_y); // RULE2
	assign cur_reg = seq_reg(kind_r, idx_r, one_reg_r); // RULE3 RULE20
	assign wr_ok   = idle && reg_we;
	assign alu_ok  = idle && alu_we;
	assign cap     = (state_r == ST_POP_CAP);

	// Byte that a push step places on the stack
	logic [7:0] push_byte;
	always_comb begin
		case (cur_reg)
			crs_pkg::REG_ACC:   push_byte = acc_r;
			crs_pkg::REG_IDX_X: push_byte = idx_x_r;
			crs_pkg::REG_IDX_Y: push_byte = idx_y_r;
			crs_pkg::REG_SPL:   push_byte = stack_pointer[7:0];
			crs_pkg::REG_FLAGS: push_byte = flag_register; // RULE6
			crs_pkg::REG_PCL:   push_byte = instr_ptr_low;
			crs_pkg::REG_PCH:   push_byte = instr_ptr_high;
			default:            push_byte = 8'h00;
		endcase
	end

	// Sequence control: one byte per cycle on push, three cycles per pop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_r   <= ST_IDLE;
			kind_r    <= crs_pkg::CMD_NONE;
			one_reg_r <= crs_pkg::REG_ACC;
			idx_r     <= 3'h0;
			len_r     <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (go) begin
						kind_r    <= cmd;
						one_reg_r <= redirect(cmd_reg, pre_y);
						idx_r     <= 3'h0;
						len_r     <= seq_len(cmd); // RULE19
						state_r   <= is_push_cmd ? ST_PUSH : ST_POP_ISSUE;
					end
				end
				ST_PUSH: begin
					idx_r <= idx_r + 3'h1;
					if (idx_r == len_r - 3'h1)
						state_r <= ST_IDLE;
				end
				ST_POP_ISSUE: state_r <= ST_POP_HOLD;
				ST_POP_HOLD:  state_r <= ST_POP_CAP;
				ST_POP_CAP: begin
					idx_r   <= idx_r + 3'h1;
					state_r <= (idx_r == len_r - 3'h1) ? ST_IDLE : ST_POP_ISSUE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Stack memory port; a push writes at the pointer, a pop reads one above
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stk_wr_r    <= 1'b0;
			stk_rd_r    <= 1'b0;
			stk_addr_r  <= crs_pkg::SP_RESET;
			stk_wdata_r <= 8'h00;
		end else begin
			stk_wr_r <= (state_r == ST_PUSH);
			stk_rd_r <= (state_r == ST_POP_ISSUE);
			if (state_r == ST_PUSH) begin
				stk_addr_r  <= stack_pointer; // RULE15 RULE19
				stk_wdata_r <= push_byte;
			end else if (state_r == ST_POP_ISSUE) begin
				stk_addr_r <= crs_pkg::crs_sp_step(stack_pointer, 1'b1); // RULE15
			end
		end
	end

	// Status for the sequencer: done pulses on the last byte
	logic last_step;
	assign last_step = ((state_r == ST_PUSH) || cap) && (idx_r == len_r - 3'h1);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy_r     <= 1'b0;
			seq_done_r <= 1'b0;
		end else begin
			busy_r     <= go || (!idle && !last_step);
			seq_done_r <= last_step;
		end
	end

	// Accumulator
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acc_r <= 8'h00;
		end else if (cap && cur_reg == crs_pkg::REG_ACC) begin
			acc_r <= stk_rdata;
		end else if (alu_ok && asel == crs_pkg::REG_ACC) begin
			acc_r <= alu_result; // RULE1
		end else if (wr_ok && wsel == crs_pkg::REG_ACC) begin
			acc_r <= reg_wdata; // RULE1
		end
	end

	// First index
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			idx_x_r <= 8'h00;
		end else if (cap && cur_reg == crs_pkg::REG_IDX_X) begin
			idx_x_r <= stk_rdata;
		end else if (alu_ok && asel == crs_pkg::REG_IDX_X) begin
			idx_x_r <= alu_result;
		end else if (wr_ok && wsel == crs_pkg::REG_IDX_X) begin
			idx_x_r <= reg_wdata; // RULE2
		end
	end

	// Second index; interrupt sequences never name it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			idx_y_r <= 8'h00;
		end else if (cap && cur_reg == crs_pkg::REG_IDX_Y) begin
			idx_y_r <= stk_rdata;
		end else if (alu_ok && asel == crs_pkg::REG_IDX_Y) begin
			idx_y_r <= alu_result; // RULE2
		end else if (wr_ok && wsel == crs_pkg::REG_IDX_Y) begin
			idx_y_r <= reg_wdata; // RULE2 RULE3
		end
	end

	// Pointer low byte; increments carry into the high byte below
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			instr_ptr_low <= crs_pkg::IP_RESET[7:0];
		end else if (cap && cur_reg == crs_pkg::REG_PCL) begin
			instr_ptr_low <= stk_rdata; // RULE4
		end else if (ip_low_we) begin
			instr_ptr_low <= ip_wdata; // RULE4
		end else if (ip_inc) begin
			instr_ptr_low <= instr_ptr_low + 8'h01;
		end
	end

	// Pointer high byte
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			instr_ptr_high <= crs_pkg::IP_RESET[15:8];
		end else if (cap && cur_reg == crs_pkg::REG_PCH) begin
			instr_ptr_high <= stk_rdata; // RULE4
		end else if (ip_high_we) begin
			instr_ptr_high <= ip_wdata; // RULE4
		end else if (ip_inc && !ip_low_we && instr_ptr_low == 8'hff) begin
			instr_ptr_high <= instr_ptr_high + 8'h01;
		end
	end

	// Mask is set on the edge that latches the flags byte for writing, so return restores the old mask
	logic entry_done;
	logic flags_load;
	assign entry_done = last_step && (kind_r == crs_pkg::CMD_INT_ENTRY); // RULE8
	assign flags_load = (cap && cur_reg == crs_pkg::REG_FLAGS) || (wr_ok && wsel == crs_pkg::REG_FLAGS); // RULE6 RULE10

	crs_flag_unit u_flags (
		.ref_clk       (ref_clk),
		.resetn        (resetn),
		.alu_upd       (alu_ok),
		.alu_result    (alu_result),
		.half_en       (alu_ok && alu_half_en),
		.alu_half      (alu_half),
		.carry_en      (alu_ok && alu_carry_en),
		.alu_carry     (alu_carry),
		.carry_set     (idle && carry_set_instr),
		.carry_clr     (idle && carry_clear_instr),
		.mask_set      (entry_done || (idle && mask_instr)),
		.mask_clr      (idle && unmask_instr),
		.load_en       (flags_load),
		.load_data     (cap ? stk_rdata : reg_wdata),
		.flag_register (flag_register)
	);

	crs_stack_unit u_stack (
		.ref_clk       (ref_clk),
		.resetn        (resetn),
		.push_dec      (state_r == ST_PUSH),
		.pop_inc       (state_r == ST_POP_ISSUE),
		.stack_reset   (idle && stack_reset_instr),
		.low_we        (wr_ok && wsel == crs_pkg::REG_SPL),
		.low_wdata     (reg_wdata),
		.stack_pointer (stack_pointer)
	);

	// Pending request latch; a new request wins over the clear at entry
	logic mask_bit;
	assign mask_bit = flag_register[crs_pkg::FLG_I];
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			int_pending_r <= 1'b0;
		end else if (irq_req) begin
			int_pending_r <= 1'b1; // RULE9
		end else if (go && cmd == crs_pkg::CMD_INT_ENTRY && !cmd_trap) begin
			int_pending_r <= 1'b0;
		end
	end

	// Service permission ignores the priority of the running routine
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			int_ready_r <= 1'b0;
		end else begin
			int_ready_r <= int_pending_r && !mask_bit && idle && !go; // RULE8 RULE9 RULE10
		end
	end

	// Branch test, answered one cycle after the request
	logic cond_bit;
	always_comb begin
		case (cond_sel)
			crs_pkg::COND_H: cond_bit = flag_register[crs_pkg::FLG_H];
			crs_pkg::COND_I: cond_bit = flag_register[crs_pkg::FLG_I];
			crs_pkg::COND_N: cond_bit = flag_register[crs_pkg::FLG_N];
			crs_pkg::COND_Z: cond_bit = flag_register[crs_pkg::FLG_Z];
			crs_pkg::COND_C: cond_bit = flag_register[crs_pkg::FLG_C];
			default:         cond_bit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			branch_valid_r <= 1'b0;
			branch_take_r  <= 1'b0;
		end else begin
			branch_valid_r <= cond_req;
			branch_take_r  <= cond_req && (cond_bit == cond_when_set); // RULE14
		end
	end

endmodule

// ==== core/crs_pkg.sv ====
package crs_pkg;

	// Data and address widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;

	// Stack pointer: 64-byte stack, upper ten bits held by hardware
	localparam int              SP_LOW_W  = 6;
	localparam logic [15:0]     SP_RESET  = 16'h00ff;
	localparam logic [15:0]     SP_FIXED  = 16'h00c0;

	// Flag register field positions and fixed values
	localparam int              FLG_C     = 0;
	localparam int              FLG_Z     = 1;
	localparam int              FLG_N     = 2;
	localparam int              FLG_I     = 3;
	localparam int              FLG_H     = 4;
	localparam logic [2:0]      FLG_ONES  = 3'h7;
	localparam logic [7:0]      FLG_RESET = 8'he8;

	// Instruction pointer reset value
	localparam logic [15:0]     IP_RESET  = 16'h0000;

	// Stack bytes used by each context sequence
	localparam logic [2:0]      LEN_INT   = 3'h5;
	localparam logic [2:0]      LEN_CALL  = 3'h2;
	localparam logic [2:0]      LEN_ONE   = 3'h1;

	// Stack sequences started by the decoder or the interrupt sequencer
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_PUSH,
		CMD_POP,
		CMD_CALL,
		CMD_RET,
		CMD_INT_ENTRY,
		CMD_INTERRUPT_RETURN_INSTR
	} crs_cmd_type;

	// Register selection
	typedef enum logic [2:0] {
		REG_ACC,
		REG_IDX_X,
		REG_IDX_Y,
		REG_SPL,
		REG_FLAGS,
		REG_PCL,
		REG_PCH
	} crs_reg_type;

	// Branch conditions
	typedef enum logic [2:0] {
		COND_H,
		COND_I,
		COND_N,
		COND_Z,
		COND_C
	} crs_cond_type;

	// One wrapping stack step, up for pop, down for push
	function automatic logic [15:0] crs_sp_step(input logic [15:0] sp, input logic up);
		logic [5:0] low;
		low = up ? (sp[5:0] + 6'h01) : (sp[5:0] - 6'h01);
		return {SP_FIXED[15:6], low};
	endfunction

endpackage

// ==== core/crs_stack_unit.sv ====
`timescale 1ns/1ps
module crs_stack_unit (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Stack control
	input  wire logic        push_dec,
	input  wire logic        pop_inc,
	input  wire logic        stack_reset,
	input  wire logic        low_we,
	input  wire logic [7:0]  low_wdata,
	// Current pointer
	output logic      [15:0] stack_pointer
);

	// Only the six low bits move; the rest stay fixed, so wrap is silent
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stack_pointer <= crs_pkg::SP_RESET; // RULE16
		end else if (stack_reset) begin
			stack_pointer <= crs_pkg::SP_RESET; // RULE16
		end else if (low_we) begin
			stack_pointer <= {crs_pkg::SP_FIXED[15:6], low_wdata[5:0]}; // RULE17
		end else if (push_dec) begin
			stack_pointer <= crs_pkg::crs_sp_step(stack_pointer, 1'b0); // RULE15 RULE18
		end else if (pop_inc) begin
			stack_pointer <= crs_pkg::crs_sp_step(stack_pointer, 1'b1); // RULE15 RULE18
		end
	end

endmodule

// ==== core/crs_flag_unit.sv ====
`timescale 1ns/1ps
module crs_flag_unit (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Result updates
	input  wire logic        alu_upd,
	input  wire logic [7:0]  alu_result,
	input  wire logic        half_en,
	input  wire logic        alu_half,
	input  wire logic        carry_en,
	input  wire logic        alu_carry,
	input  wire logic        carry_set,
	input  wire logic        carry_clr,
	// Mask control
	input  wire logic        mask_set,
	input  wire logic        mask_clr,
	// Whole-register load
	input  wire logic        load_en,
	input  wire logic [7:0]  load_data,
	// Register value
	output logic      [7:0]  flag_register
);

	logic h_r;
	logic i_r;
	logic n_r;
	logic z_r;
	logic c_r;

	// Top three bits are constant ones
	assign flag_register = {crs_pkg::FLG_ONES, h_r, i_r, n_r, z_r, c_r}; // RULE5

	// Half carry only moves on add type results or a full load
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			h_r <= crs_pkg::FLG_RESET[crs_pkg::FLG_H];
		end else if (load_en) begin
			h_r <= load_data[crs_pkg::FLG_H]; // RULE6
		end else if (half_en) begin
			h_r <= alu_half; // RULE7
		end
	end

	// Mask: hardware set has priority so an entry is never left unmasked
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			i_r <= crs_pkg::FLG_RESET[crs_pkg::FLG_I]; // RULE5
		end else if (mask_set) begin
			i_r <= 1'b1; // RULE8
		end else if (load_en) begin
			i_r <= load_data[crs_pkg::FLG_I]; // RULE10
		end else if (mask_clr) begin
			i_r <= 1'b0; // RULE8
		end
	end

	// Sign and zero follow every result that no flag load overrides
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			n_r <= crs_pkg::FLG_RESET[crs_pkg::FLG_N];
			z_r <= crs_pkg::FLG_RESET[crs_pkg::FLG_Z];
		end else if (load_en) begin
			n_r <= load_data[crs_pkg::FLG_N];
			z_r <= load_data[crs_pkg::FLG_Z];
		end else if (alu_upd) begin
			n_r <= alu_result[7]; // RULE11
			z_r <= (alu_result == 8'h00); // RULE12
		end
	end

	// Carry: explicit set and clear beat an arithmetic update
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			c_r <= crs_pkg::FLG_RESET[crs_pkg::FLG_C];
		end else if (load_en) begin
			c_r <= load_data[crs_pkg::FLG_C];
		end else if (carry_set) begin
			c_r <= 1'b1; // RULE13
		end else if (carry_clr) begin
			c_r <= 1'b0; // RULE13
		end else if (carry_en) begin
			c_r <= alu_carry; // RULE13
		end
	end

endmodule

// ==== verif/crs_core_regs_chk.sv ====
`timescale 1ns/1ps
module crs_core_regs_chk (
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            resetn,
	// Watched inputs
	input  wire logic            alu_we,
	input  wire logic [7:0]      alu_result,
	input  wire logic            reg_we,
	input  crs_pkg::crs_reg_type reg_sel,
	input  wire logic            mask_instr,
	input  wire logic            unmask_instr,
	input  wire logic            cond_req,
	input  crs_pkg::crs_cond_type cond_sel,
	input  wire logic            cond_when_set,
	input  wire logic            irq_req,
	// Watched outputs
	input  wire logic            stk_wr_r,
	input  wire logic            stk_rd_r,
	input  wire logic [15:0]     stk_addr_r,
	input  wire logic [7:0]      flag_register,
	input  wire logic [15:0]     stack_pointer,
	input  wire logic            busy_r,
	input  wire logic            int_pending_r,
	input  wire logic            int_ready_r,
	input  wire logic            branch_valid_r,
	input  wire logic            branch_take_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// Flag picked by the branch selector, and the mask alone
	logic cbit;
	logic imask;
	assign cbit  = flag_register[3'd4 - cond_sel];
	assign imask = flag_register[3];

	// Flag load on the same edge would win, so leave it out
	logic plain_alu;
	assign plain_alu = alu_we && !busy_r && !(reg_we && reg_sel == crs_pkg::REG_FLAGS);

	AST_SP_HI: assert property (stack_pointer[15:6] == 10'h003) else $error("stack pointer top bits moved");
	AST_FLG_ONES: assert property (flag_register[7:5] == 3'h7) else $error("flag top bits not ones");
	AST_NEG: assert property (plain_alu |=> flag_register[2] == ($past(alu_result) >= 8'h80))
		else $error("negative flag wrong");
	AST_ZERO: assert property (plain_alu |=> flag_register[1] == ($past(alu_result) == 8'h00))
		else $error("zero flag wrong");
	AST_PUSH: assert property (stk_wr_r |-> stack_pointer[5:0] == stk_addr_r[5:0] - 6'h01)
		else $error("push not followed by decrement");
	AST_POP: assert property (stk_rd_r |-> stack_pointer == stk_addr_r && !stk_wr_r)
		else $error("pop address not incremented pointer");
	AST_BRANCH: assert property (cond_req |=> branch_valid_r && branch_take_r == ($past(cbit) == $past(cond_when_set)))
		else $error("branch answer wrong");
	AST_UNMASK: assert property (unmask_instr && !busy_r && !mask_instr && !reg_we |=> !imask)
		else $error("mask not cleared");
	AST_LATCH: assert property (irq_req |=> int_pending_r) else $error("request not latched");
	AST_READY: assert property (int_ready_r |-> $past(int_pending_r) && !$past(imask))
		else $error("service allowed while masked");
endmodule

bind crs_core_regs crs_core_regs_chk u_chk (.*);

// ==== verif/crs_stack_mem.sv ====
`timescale 1ns/1ps
module crs_stack_mem (
	// Clock
	input  wire logic        ref_clk,
	// Stack strobes from the register set
	input  wire logic        stk_wr_r,
	input  wire logic        stk_rd_r,
	input  wire logic [15:0] stk_addr_r,
	input  wire logic [7:0]  stk_wdata_r,
	// Read data back
	output logic      [7:0]  stk_rdata
);
	logic [7:0] mem [256];

	// Writes land on the strobe edge
	always @(posedge ref_clk)
		if (stk_wr_r)
			mem[stk_addr_r[7:0]] <= stk_wdata_r;

	// Registered read; outside its one valid cycle the bus toggles so stale data never passes
	initial stk_rdata = 8'h00;
	always @(posedge ref_clk)
		if (stk_rd_r)
			stk_rdata <= mem[stk_addr_r[7:0]];
		else
			stk_rdata <= ~stk_rdata;
endmodule

// ==== verif/crs_core_regs_tb.sv ====
`timescale 1ns/1ps
module crs_core_regs_tb;
	// Design inputs
	logic ref_clk, resetn, pre_y, reg_we, alu_we, alu_half_en, alu_half, alu_carry_en, alu_carry;
	logic carry_set_instr, carry_clear_instr, mask_instr, unmask_instr, stack_reset_instr;
	logic ip_inc, ip_low_we, ip_high_we, cmd_start, cmd_trap, cond_req, cond_when_set, irq_req;
	logic [7:0] reg_wdata, alu_result, ip_wdata, stk_rdata;
	crs_pkg::crs_reg_type reg_sel, alu_dest, cmd_reg;
	crs_pkg::crs_cmd_type cmd;
	crs_pkg::crs_cond_type cond_sel;
	// Design outputs
	logic stk_wr_r, stk_rd_r, busy_r, seq_done_r, int_pending_r, int_ready_r, branch_valid_r, branch_take_r;
	logic [15:0] stk_addr_r, stack_pointer;
	logic [7:0] stk_wdata_r, acc_r, idx_x_r, idx_y_r, instr_ptr_low, instr_ptr_high, flag_register;
	// Bench state
	int n_errors, compares, i;
	logic [7:0] ef;
	logic [7:0] ctx [5] = '{8'h34, 8'h13, 8'h11, 8'h3c, 8'he0};

	crs_core_regs u_dut (.*);
	crs_stack_mem u_mem (.ref_clk(ref_clk), .stk_wr_r(stk_wr_r), .stk_rd_r(stk_rd_r),
		.stk_addr_r(stk_addr_r), .stk_wdata_r(stk_wdata_r), .stk_rdata(stk_rdata));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Inputs move on the falling edge, away from the sampling edge
	task automatic step(input int n = 1);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input crs_pkg::crs_reg_type s, input logic [7:0] d);
		reg_we = 1'b1;
		reg_sel = s;
		reg_wdata = d;
		step();
		reg_we = 1'b0;
		step();
	endtask

	// hc holds half enable, half, carry enable, carry
	task automatic alu(input crs_pkg::crs_reg_type d, input logic [7:0] r, input logic [3:0] hc);
		alu_we = 1'b1;
		alu_dest = d;
		alu_result = r;
		{alu_half_en, alu_half, alu_carry_en, alu_carry} = hc;
		step();
		alu_we = 1'b0;
		step();
	endtask

	// A sequence may take up to 15 cycles; the bound leaves ample slack
	task automatic seq(input crs_pkg::crs_cmd_type c, input crs_pkg::crs_reg_type r);
		cmd_start = 1'b1;
		cmd = c;
		cmd_reg = r;
		step();
		cmd_start = 1'b0;
		for (i = 0; i < 40 && seq_done_r !== 1'b1; i++)
			step();
		if (i == 40) begin
			n_errors++;
			finish_test();
		end
		step();
	endtask

	initial begin
		{resetn, pre_y, reg_we, alu_we, alu_half_en, alu_half, alu_carry_en, alu_carry} = '0;
		{carry_set_instr, carry_clear_instr, mask_instr, unmask_instr, stack_reset_instr} = '0;
		{ip_inc, ip_low_we, ip_high_we, cmd_start, cmd_trap, cond_req, cond_when_set, irq_req} = '0;
		{reg_wdata, alu_result, ip_wdata} = '0;
		reg_sel = crs_pkg::REG_ACC;
		alu_dest = crs_pkg::REG_ACC;
		cmd_reg = crs_pkg::REG_ACC;
		cmd = crs_pkg::CMD_NONE;
		cond_sel = crs_pkg::COND_H;
		step(10);
		resetn = 1'b1;
		check("flags", flag_register, 8'he8);
		check("sp", stack_pointer, 16'h00ff);
		$display("test reset done");

		alu(crs_pkg::REG_ACC, 8'h80, 4'h0);
		check("acc", acc_r, 8'h80);
		check("flags", flag_register, 8'hec);
		pre_y = 1'b1;
		alu(crs_pkg::REG_IDX_X, 8'h5a, 4'h0);
		pre_y = 1'b0;
		check("y", idx_y_r, 8'h5a);
		check("x", idx_x_r, 8'h00);
		alu(crs_pkg::REG_ACC, 8'h00, 4'hf);
		check("flags", flag_register, 8'hfb);
		ef = 8'hfb;
		// Every flag in both senses
		cond_req = 1'b1;
		for (int k = 0; k < 10; k++) begin
			cond_sel = crs_pkg::crs_cond_type'(k / 2);
			cond_when_set = k[0];
			step();
			check("take", branch_take_r, ef[4 - k / 2] == k[0]);
		end
		cond_req = 1'b0;
		carry_clear_instr = 1'b1;
		step();
		carry_clear_instr = 1'b0;
		check("flags", flag_register, 8'hfa);
		carry_set_instr = 1'b1;
		step();
		carry_set_instr = 1'b0;
		check("flags", flag_register, 8'hfb);
		alu(crs_pkg::REG_ACC, 8'h01, 4'ha);
		check("flags", flag_register, 8'he8);
		$display("test flags done");

		wr(crs_pkg::REG_ACC, 8'h3c);
		wr(crs_pkg::REG_SPL, 8'hc0);
		check("sp", stack_pointer, 16'h00c0);
		seq(crs_pkg::CMD_PUSH, crs_pkg::REG_ACC);
		check("mem", u_mem.mem[8'hc0], 8'h3c);
		check("sp", stack_pointer, 16'h00ff);
		seq(crs_pkg::CMD_POP, crs_pkg::REG_IDX_X);
		check("x", idx_x_r, 8'h3c);
		check("sp", stack_pointer, 16'h00c0);
		stack_reset_instr = 1'b1;
		step();
		stack_reset_instr = 1'b0;
		check("sp", stack_pointer, 16'h00ff);
		$display("test stack done");

		irq_req = 1'b1;
		step();
		irq_req = 1'b0;
		step();
		check("pend", int_pending_r, 1'b1);
		check("ready", int_ready_r, 1'b0);
		unmask_instr = 1'b1;
		step();
		unmask_instr = 1'b0;
		step();
		check("ready", int_ready_r, 1'b1);
		wr(crs_pkg::REG_IDX_X, 8'h11);
		ip_wdata = 8'hff;
		ip_low_we = 1'b1;
		step();
		ip_low_we = 1'b0;
		ip_wdata = 8'h12;
		ip_high_we = 1'b1;
		step();
		ip_high_we = 1'b0;
		ip_inc = 1'b1;
		step();
		ip_inc = 1'b0;
		check("iph", instr_ptr_high, 8'h13);
		ip_wdata = 8'h34;
		ip_low_we = 1'b1;
		step();
		ip_low_we = 1'b0;
		seq(crs_pkg::CMD_INT_ENTRY, crs_pkg::REG_ACC);
		for (int k = 0; k < 5; k++)
			check("ctx", u_mem.mem[8'hff - k], ctx[k]);
		check("sp", stack_pointer, 16'h00fa);
		check("flags", flag_register, 8'he8);
		check("pend", int_pending_r, 1'b0);
		wr(crs_pkg::REG_ACC, 8'h00);
		wr(crs_pkg::REG_IDX_X, 8'h00);
		seq(crs_pkg::CMD_INTERRUPT_RETURN_INSTR, crs_pkg::REG_ACC);
		check("acc", acc_r, 8'h3c);
		check("x", idx_x_r, 8'h11);
		check("ip", {instr_ptr_high, instr_ptr_low}, 16'h1334);
		check("flags", flag_register, 8'he0);
		check("sp", stack_pointer, 16'h00ff);
		check("y", idx_y_r, 8'h5a);
		mask_instr = 1'b1;
		step();
		mask_instr = 1'b0;
		check("flags", flag_register, 8'he8);
		ip_wdata = 8'h56;
		ip_low_we = 1'b1;
		step();
		ip_low_we = 1'b0;
		seq(crs_pkg::CMD_CALL, crs_pkg::REG_ACC);
		check("call", {u_mem.mem[8'hfe], u_mem.mem[8'hff]}, 16'h1356);
		check("sp", stack_pointer, 16'h00fd);
		ip_inc = 1'b1;
		step();
		ip_inc = 1'b0;
		seq(crs_pkg::CMD_RET, crs_pkg::REG_ACC);
		check("ip", {instr_ptr_high, instr_ptr_low}, 16'h1356);
		$display("test interrupt done");
		finish_test();
	end
endmodule
